// file: logic/t1rx_decode_maint.sv
// Purpose: T1/J1 receive decode, loss detection and maintenance functions
// Assumes: line pins are asynchronous; transmit strobe is on aclk
// Notes: AXI4-Lite slave; all outputs registered
`timescale 1ns/100ps
module t1rx_decode_maint #(
  parameter int ONE_SEC_CYCLES = t1rx_pkg::REPORT_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire t1rx_pkg::t1rx_axil_req_t axil_req,
  output t1rx_pkg::t1rx_axil_rsp_t axil_rsp,
  input wire t1rx_pkg::t1rx_line_t line_in,
  input wire logic tx_data_in,
  input wire logic tx_bit_valid,
  output logic rx_data,
  output logic rx_data_valid,
  output logic tx_data,
  output logic tx_data_valid,
  output logic tx_bpv,
  output t1rx_pkg::t1rx_loop_t loop_en,
  output logic rx_power_down,
  output logic equalizer_on,
  output logic [5:0] loss_threshold_db,
  output logic peak_window_end,
  output logic los,
  output logic irq
);
  import t1rx_pkg::*;

  if (ONE_SEC_CYCLES < 2) begin : g_chk
    $error("ONE_SEC_CYCLES must be at least 2");
  end

  function automatic logic is_mapped(logic [9:0] idx);
    return idx inside {IDX_RX_CFG_A, IDX_RX_CFG_B, IDX_RX_CFG_C, IDX_LOOP,
      IDX_LOS_RESP, IDX_ERR_CTRL, IDX_IRQ_STATUS, IDX_IRQ_CLEAR,
      IDX_IRQ_ENABLE, IDX_COUNT_LOW, IDX_COUNT_HIGH, IDX_LINE_STATUS};
  endfunction : is_mapped

  function automatic logic [6:0] exz_limit(logic ami, logic fcc);
    if (!ami) begin
      return EXZ_B8ZS;
    end
    return fcc ? EXZ_AMI_FCC : EXZ_AMI_ANSI;
  endfunction : exz_limit

  //////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q, rd_word;
  logic aw_held_q, w_held_q, wlane_q;
  logic [9:0] aw_idx_q;
  logic [7:0] wbyte_q;
  logic wr_fire;
  logic [7:0] cfg_a_q, cfg_b_q, cfg_c_q, loop_q, losr_q, ectl_q, ectl_prev_q;
  logic [IRQ_W-1:0] irq_en_q, irq_st_q, irq_clr, irq_ev;
  logic [15:0] cnt_q, snap_q;
  logic los_q;

  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign axil_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
    bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
    rresp: rresp_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_idx_q <= 10'h000;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awready_q && axil_req.awvalid) begin
        aw_idx_q <= axil_req.awaddr[11:2];
        aw_held_q <= 1'b1;
        awready_q <= 1'b0;
      end
      if (wready_q && axil_req.wvalid) begin
        wbyte_q <= axil_req.wdata[7:0];
        wlane_q <= axil_req.wstrb[0];
        w_held_q <= 1'b1;
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= is_mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
      if (bvalid_q && axil_req.bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (axil_req.araddr[11:2])
      IDX_RX_CFG_A: rd_word[7:0] = cfg_a_q;
      IDX_RX_CFG_B: rd_word[7:0] = cfg_b_q;
      IDX_RX_CFG_C: rd_word[7:0] = cfg_c_q;
      IDX_LOOP: rd_word[7:0] = loop_q;
      IDX_LOS_RESP: rd_word[7:0] = losr_q;
      IDX_ERR_CTRL: rd_word[7:0] = ectl_q;
      IDX_IRQ_STATUS: rd_word[IRQ_W-1:0] = irq_st_q;
      IDX_IRQ_ENABLE: rd_word[IRQ_W-1:0] = irq_en_q;
      IDX_COUNT_LOW: rd_word[7:0] = snap_q[7:0];
      IDX_COUNT_HIGH: rd_word[7:0] = snap_q[15:8];
      IDX_LINE_STATUS: rd_word[0] = los_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (arready_q && axil_req.arvalid) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= is_mapped(axil_req.araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && axil_req.rready) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // only byte lane 0 carries register data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_a_q <= RST_RX_CFG_A;
      cfg_b_q <= RST_RX_CFG_B;
      cfg_c_q <= RST_RX_CFG_C;
      loop_q <= RST_ZERO;
      losr_q <= RST_ZERO;
      ectl_q <= RST_ZERO;
      irq_en_q <= '0;
    end else if (wr_fire && wlane_q) begin
      unique case (aw_idx_q)
        IDX_RX_CFG_A: cfg_a_q <= wbyte_q & MSK_RX_CFG_A;
        IDX_RX_CFG_B: cfg_b_q <= wbyte_q & MSK_RX_CFG_B;
        IDX_RX_CFG_C: cfg_c_q <= wbyte_q & MSK_RX_CFG_C;
        IDX_LOOP: loop_q <= wbyte_q & MSK_LOOP;
        IDX_LOS_RESP: losr_q <= wbyte_q & MSK_LOS_RESP;
        IDX_ERR_CTRL: ectl_q <= wbyte_q & MSK_ERR_CTRL;
        IDX_IRQ_ENABLE: irq_en_q <= wbyte_q[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  assign irq_clr = (wr_fire && wlane_q && aw_idx_q == IDX_IRQ_CLEAR) ?
    wbyte_q[IRQ_W-1:0] : '0;

  //////////////////////////////////////////////////////////////////////////
  // line input synchroniser: change taken when stages two and three agree
  logic [4:0] s1_q, s2_q, s3_q, f_q;
  t1rx_line_t lf;
  logic clk_prev_q, bit_ev, mark_in, pwr_off, ami;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q <= 5'h00;
      s2_q <= 5'h00;
      s3_q <= 5'h00;
      f_q <= 5'h00;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= line_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= (s2_q & s3_q) | (f_q & (s2_q ^ s3_q));
      clk_prev_q <= lf.bit_clk;
    end
  end

  assign lf = f_q;
  assign pwr_off = cfg_a_q[RXA_OFF_BIT];
  assign ami = cfg_a_q[RXA_CODE_BIT];
  // a powered-down path sees no bit intervals at all
  assign bit_ev = lf.bit_clk && !clk_prev_q && !pwr_off;
  assign mark_in = lf.pos | lf.neg;

  //////////////////////////////////////////////////////////////////////////
  // line decoder: eight-bit delay; a B8ZS hit clears dq_q for one bit, so only the first bit of the word is blanked
  logic [7:0] mark_q, pol_q, dq_q, nm, np;
  logic b8zs_hit, dec_bit;

  assign nm = {mark_q[6:0], mark_in};
  assign np = {pol_q[6:0], lf.pos};
  assign b8zs_hit = !ami && nm == 8'h1b && np[4] != np[3] &&
    np[1] == np[3] && np[0] != np[1];
  assign dec_bit = dq_q[7];

  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_off) begin
      mark_q <= 8'h00;
      pol_q <= 8'h00;
      dq_q <= 8'h00;
    end else if (bit_ev) begin
      mark_q <= nm;
      pol_q <= np;
      dq_q <= b8zs_hit ? 8'h00 : nm;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_off) begin
      rx_data <= 1'b0;
      rx_data_valid <= 1'b0;
    end else begin
      rx_data_valid <= bit_ev;
      if (bit_ev) begin
        rx_data <= (losr_q[LR_RAISE_BIT] && los_q) | dec_bit;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // loss of signal declare and clear
  logic [10:0] below_cnt_q, declare_n;
  logic [6:0] win_cnt_q, win_zrun_q;
  logic [7:0] win_marks_q, marks_total;
  logic win_bad_q, los_set, los_clr;

  assign declare_n = losr_q[LR_LAC_BIT] ? LOS_DECLARE_E1 : LOS_DECLARE_T1;
  assign marks_total = win_marks_q + {7'h00, mark_in};
  assign los_set = bit_ev && !los_q && lf.below &&
    below_cnt_q == declare_n - 11'h001;
  assign los_clr = bit_ev && los_q && win_cnt_q == CLEAR_WIN_LAST &&
    lf.adequate && marks_total >= CLEAR_MIN_MARKS && !win_bad_q &&
    !(!mark_in && win_zrun_q == CLEAR_ZERO_LAST);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      los_q <= 1'b0;
      below_cnt_q <= 11'h000;
    end else if (bit_ev) begin
      if (los_set) begin
        los_q <= 1'b1;
      end else if (los_clr) begin
        los_q <= 1'b0;
      end
      if (!lf.below) begin
        below_cnt_q <= 11'h000;
      end else if (below_cnt_q != LOS_DECLARE_E1) begin
        below_cnt_q <= below_cnt_q + 11'h001;
      end
    end
  end

  // clear criterion judged over back-to-back 128-bit windows
  always_ff @(posedge aclk) begin
    if (!aresetn || !los_q) begin
      win_cnt_q <= 7'h00;
      win_marks_q <= 8'h00;
      win_zrun_q <= 7'h00;
      win_bad_q <= 1'b0;
    end else if (bit_ev) begin
      win_cnt_q <= win_cnt_q + 7'h01;
      win_zrun_q <= mark_in ? 7'h00 : win_zrun_q + 7'h01;
      if (win_cnt_q == CLEAR_WIN_LAST) begin
        win_marks_q <= 8'h00;
        win_bad_q <= 1'b0;
      end else begin
        win_marks_q <= marks_total;
        if (!mark_in && win_zrun_q == CLEAR_ZERO_LAST) begin
          win_bad_q <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // excessive zeros, error counter and reporting
  logic [6:0] zrun_q, zlim;
  logic exz_ev, trf_rise, bpv_rise, report_ev, sec_tick;
  logic [31:0] sec_cnt_q;

  assign zlim = exz_limit(ami, ectl_q[EC_ZDEF_BIT]);
  assign exz_ev = bit_ev && !dec_bit && zrun_q == zlim;
  // rising edge only: software must drop the bit before the next update
  assign trf_rise = ectl_q[EC_TRF_BIT] && !ectl_prev_q[EC_TRF_BIT];
  assign bpv_rise = ectl_q[EC_BPV_BIT] && !ectl_prev_q[EC_BPV_BIT];
  assign sec_tick = sec_cnt_q == 32'(ONE_SEC_CYCLES - 1);
  assign report_ev = ectl_q[EC_MODE_BIT] ? sec_tick :
    trf_rise;

  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_off) begin
      zrun_q <= 7'h00;
    end else if (bit_ev) begin
      if (dec_bit) begin
        zrun_q <= 7'h00;
      end else if (zrun_q != 7'h7f) begin
        zrun_q <= zrun_q + 7'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ectl_prev_q <= RST_ZERO;
    end else begin
      ectl_prev_q <= ectl_q;
    end
  end

  // saturates rather than wrapping, so a stale report never looks small
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else if (exz_ev && ectl_q[EC_ERR_LSB+:2] == ERR_COUNT_ON &&
        cnt_q != 16'hffff) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ectl_q[EC_MODE_BIT] || sec_tick) begin
      sec_cnt_q <= 32'h0000_0000;
    end else begin
      sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_q <= 16'h0000;
    end else if (report_ev) begin
      snap_q <= cnt_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // transmit maintenance: all ones and single violation insertion
  logic bpv_pend_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bpv_pend_q <= 1'b0;
      tx_data <= 1'b0;
      tx_data_valid <= 1'b0;
      tx_bpv <= 1'b0;
    end else begin
      tx_data_valid <= tx_bit_valid;
      tx_bpv <= tx_bit_valid && bpv_pend_q;
      if (tx_bit_valid) begin
        tx_data <= (losr_q[LR_TX_ALL_ONES_ON_LOSS_BIT] && los_q) | tx_data_in;
      end
      // a new request in the cycle of insertion is kept, not lost
      if (bpv_rise) begin
        bpv_pend_q <= 1'b1;
      end else if (tx_bit_valid) begin
        bpv_pend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // peak window, threshold, static controls, interrupt
  logic [7:0] pk_cnt_q, pk_last;
  logic [8:0] pk_period;

  assign pk_period = PEAK_BASE_BITS << cfg_c_q[RXC_PEAK_LSB+:2];
  assign pk_last = 8'(pk_period - 9'h001);
  assign irq_ev = {report_ev, exz_ev, los_clr, los_set};

  always_ff @(posedge aclk) begin
    if (!aresetn || pwr_off) begin
      pk_cnt_q <= 8'h00;
      peak_window_end <= 1'b0;
    end else begin
      peak_window_end <= bit_ev && pk_cnt_q >= pk_last;
      if (bit_ev) begin
        pk_cnt_q <= (pk_cnt_q >= pk_last) ? 8'h00 : pk_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_threshold_db <= 6'h00;
      equalizer_on <= 1'b0;
      rx_power_down <= 1'b0;
      loop_en <= '0;
      los <= 1'b0;
    end else begin
      equalizer_on <= cfg_b_q[RXB_EQ_BIT];
      // only meaningful with the equalizer on (long haul)
      if (!cfg_b_q[RXB_EQ_BIT]) begin
        loss_threshold_db <= 6'h00;
      end else if (cfg_b_q[4:0] >= THR_MAX_CODE) begin
        loss_threshold_db <= THR_MAX_DB;
      end else begin
        loss_threshold_db <= THR_BASE_DB + {cfg_b_q[4:0], 1'b0};
      end
      rx_power_down <= pwr_off;
      loop_en <= {loop_q[6:4], loop_q[2:0]};
      los <= los_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_q <= '0;
      irq <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_ev;
      irq <= |(irq_st_q & irq_en_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence bpv_request;
    bpv_rise ##1 bpv_pend_q;
  endsequence

  sequence bpv_sent;
    (tx_bit_valid && !bpv_rise) ##1 (tx_bpv && !bpv_pend_q);
  endsequence

  b8zs_blank_a: assert property ((bit_ev && b8zs_hit) |=>
    (dq_q == 8'h00 && !$past(ami)))
    else $error("b8zs word not blanked");
  power_off_a: assert property (pwr_off |=> !rx_data_valid)
    else $error("receive data while powered down");
  los_declare_a: assert property ($rose(los_q) |->
    ($past(below_cnt_q) + 11'h001 == $past(declare_n)))
    else $error("loss declared at wrong count");
  los_clear_a: assert property ($fell(los_q) |->
    ($past(win_cnt_q) == CLEAR_WIN_LAST &&
     $past(marks_total) >= CLEAR_MIN_MARKS && $past(lf.adequate)))
    else $error("loss cleared without criteria");
  rx_all_ones_a: assert property ((bit_ev && los_q &&
    losr_q[LR_RAISE_BIT]) |=> rx_data)
    else $error("receive ones not inserted");
  tx_all_ones_a: assert property ((tx_bit_valid && los_q &&
    losr_q[LR_TX_ALL_ONES_ON_LOSS_BIT]) |=> tx_data)
    else $error("transmit ones not inserted");
  bpv_pend_a: assert property (bpv_rise |-> bpv_request)
    else $error("violation request lost");
  bpv_single_a: assert property ((bpv_pend_q && tx_bit_valid &&
    !bpv_rise) |-> bpv_sent)
    else $error("violation not sent");
  bpv_once_a: assert property (tx_bpv |->
    (!bpv_pend_q || $past(bpv_rise)))
    else $error("violation repeated");
  exz_limit_a: assert property (exz_ev |->
    (zrun_q == (ami ? (ectl_q[EC_ZDEF_BIT] ? 7'h50 : 7'h0f) : 7'h07)))
    else $error("zero error at wrong run length");
  count_gate_a: assert property ((exz_ev &&
    ectl_q[EC_ERR_LSB+:2] != ERR_COUNT_ON) |=> $stable(cnt_q))
    else $error("counted while disabled");
  report_copy_a: assert property (report_ev |=>
    snap_q == $past(cnt_q))
    else $error("report copy wrong");
  snapshot_hold_a: assert property (!report_ev |=>
    $stable(snap_q))
    else $error("report changed between transfers");
  peak_window_a: assert property (peak_window_end |->
    $past(pk_cnt_q) == $past(pk_last))
    else $error("peak window length wrong");

endmodule : t1rx_decode_maint

// file: logic/t1rx_pkg.sv
// Purpose: constants and carriers for the T1/J1 receive decode/maintenance block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes: register byte address is four times the register index
//
// Summary of operation
// - line code bit 0 selects B8ZS decoding, 1 selects plain AMI.
// - receive power-off bit at 1 halts the whole receive path.
// - loss declared after 175 (or 1544) consecutive low-level bit intervals.
// - loss cleared when level adequate, marks >= 12.5% and zero runs < 100 in 128 bits.
// - long haul threshold code gives -4 dB, 2 dB steps, capped at -48 dB.
// - receive all-ones bit forces received data to ones during loss.
// - transmit all-ones bit forces transmit data to ones during receive loss.
// - each 0-to-1 change of violation insert bit injects exactly one violation.
// - ANSI criterion: zero error after 15 zeros AMI, 7 zeros B8ZS.
// - FCC criterion: zero error after 80 zeros AMI, still 7 under B8ZS.
// - zero errors counted in a 16-bit counter only while enable field is 01.
// - manual mode copies counter to report registers on transfer request rise.
// - automatic mode copies counter to report registers once per second.
// - six loopback enables, each active while its bit is 1.
// - peak observation period of 32, 64, 128 or 256 bits.
package t1rx_pkg;

  // register indices; byte address is index * 4
  localparam logic [9:0] IDX_RX_CFG_A = 10'h028;
  localparam logic [9:0] IDX_RX_CFG_B = 10'h029;
  localparam logic [9:0] IDX_RX_CFG_C = 10'h02a;
  localparam logic [9:0] IDX_LOOP = 10'h02b;
  localparam logic [9:0] IDX_LOS_RESP = 10'h02c;
  localparam logic [9:0] IDX_ERR_CTRL = 10'h031;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h040;
  localparam logic [9:0] IDX_IRQ_CLEAR = 10'h041;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h042;
  localparam logic [9:0] IDX_COUNT_LOW = 10'h043;
  localparam logic [9:0] IDX_COUNT_HIGH = 10'h044;
  localparam logic [9:0] IDX_LINE_STATUS = 10'h045;

  // reset values and writable bit masks
  localparam logic [7:0] RST_RX_CFG_A = 8'h00;
  localparam logic [7:0] RST_RX_CFG_B = 8'h15;
  localparam logic [7:0] RST_RX_CFG_C = 8'h18;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] MSK_RX_CFG_A = 8'h11;
  localparam logic [7:0] MSK_RX_CFG_B = 8'h5f;
  localparam logic [7:0] MSK_RX_CFG_C = 8'h3f;
  localparam logic [7:0] MSK_LOOP = 8'h77;
  localparam logic [7:0] MSK_LOS_RESP = 8'h07;
  localparam logic [7:0] MSK_ERR_CTRL = 8'h5f;

  // field positions
  localparam int RXA_CODE_BIT = 0;
  localparam int RXA_OFF_BIT = 4;
  localparam int RXB_EQ_BIT = 6;
  localparam int RXC_PEAK_LSB = 2;
  localparam int LR_TX_ALL_ONES_ON_LOSS_BIT = 0;
  localparam int LR_RAISE_BIT = 1;
  localparam int LR_LAC_BIT = 2;
  localparam int EC_TRF_BIT = 0;
  localparam int EC_MODE_BIT = 1;
  localparam int EC_ERR_LSB = 2;
  localparam int EC_ZDEF_BIT = 4;
  localparam int EC_BPV_BIT = 6;
  localparam logic [1:0] ERR_COUNT_ON = 2'h1;
  localparam int IRQ_W = 4;
  localparam int IRQ_LOS_SET = 0;
  localparam int IRQ_LOS_CLR = 1;
  localparam int IRQ_EXZ = 2;
  localparam int IRQ_REPORT = 3;

  // bit-interval counts, threshold dB values and threshold code
  localparam logic [10:0] LOS_DECLARE_T1 = 11'h0af;
  localparam logic [10:0] LOS_DECLARE_E1 = 11'h608;
  localparam logic [6:0] CLEAR_WIN_LAST = 7'h7f;
  localparam logic [7:0] CLEAR_MIN_MARKS = 8'h10;
  localparam logic [6:0] CLEAR_ZERO_LAST = 7'h63;
  localparam logic [6:0] EXZ_AMI_ANSI = 7'h0f;
  localparam logic [6:0] EXZ_AMI_FCC = 7'h50;
  localparam logic [6:0] EXZ_B8ZS = 7'h07;
  localparam logic [8:0] PEAK_BASE_BITS = 9'h020;
  localparam logic [5:0] THR_BASE_DB = 6'h04;
  localparam logic [5:0] THR_MAX_DB = 6'h30;
  localparam logic [4:0] THR_MAX_CODE = 5'h16;

  // timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int REPORT_PERIOD_MS = 1000;
  localparam int REPORT_CYCLES = REPORT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } t1rx_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } t1rx_axil_rsp_t;

  typedef struct packed {
    logic bit_clk;
    logic pos;
    logic neg;
    logic below;
    logic adequate;
  } t1rx_line_t;

  typedef struct packed {
    logic local_digital_loop_one;
    logic system_local_loop;
    logic system_remote_loop;
    logic remote_loop;
    logic analog_loop;
    logic local_digital_loop_two;
  } t1rx_loop_t;

endpackage : t1rx_pkg

// file: tb/t1rx_line_model.sv
// Purpose: line interface stand-in for the receive pins
// Assumes: one bit is 16 aclk cycles; bit clock stops while run is low
// Notes: pins move on the falling bit clock, half a bit before use
`timescale 1ns/100ps
module t1rx_line_model (
  input wire logic aclk,
  input wire logic run,
  input wire logic marks,
  input wire logic low_level,
  output t1rx_pkg::t1rx_line_t line
);
  import t1rx_pkg::*;
  logic [2:0] div_q = 3'h0;
  logic pol_q = 1'b0;
  initial line = '0;
  always @(posedge aclk) begin
    div_q <= div_q + 3'h1;
    if (div_q == 3'h7) begin
      line.bit_clk <= run & ~line.bit_clk;
      if (line.bit_clk) begin
        // alternate polarity so marks stay legal bipolar
        line.pos <= marks & ~pol_q;
        line.neg <= marks & pol_q;
        pol_q <= pol_q ^ marks;
        line.below <= low_level;
        line.adequate <= ~low_level;
      end
    end
  end
endmodule : t1rx_line_model

// file: tb/t1rx_decode_maint_tb.sv
// Purpose: self-checking bench for the receive decode block
// Assumes: report period shortened to 200 cycles
// Notes: reads queue their expected word; a monitor compares
`timescale 1ns/100ps
module t1rx_decode_maint_tb;
  import t1rx_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  t1rx_axil_req_t req = '0;
  t1rx_axil_rsp_t rsp;
  t1rx_line_t line;
  t1rx_loop_t loop_en;
  logic tx_in = 1'b0, tvalid = 1'b0, low = 1'b0, marks = 1'b1;
  logic rx_data, rx_dv, tx_data, tx_dv, tx_bpv, los, irq, eq, pd, pwe;
  logic ones_exp = 1'b0;
  logic [5:0] thr;
  logic [7:0] d;
  logic [33:0] e;
  logic [33:0] expq[$];
  logic [4:0] codes[4] = '{5'h00, 5'h01, 5'h16, 5'h1f};
  logic [5:0] dbs[4] = '{6'h04, 6'h06, 6'h30, 6'h30};
  int miscompares = 0, comparisons = 0, nb = 0, bpvn = 0, pk = 0;
  int seed = 32'hadce;
  always #10 aclk = ~aclk;
  t1rx_decode_maint #(.ONE_SEC_CYCLES(200)) t1rx_decode_maint_i (
    .aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
    .line_in(line), .tx_data_in(tx_in), .tx_bit_valid(tvalid),
    .rx_data(rx_data), .rx_data_valid(rx_dv), .tx_data(tx_data),
    .tx_data_valid(tx_dv), .tx_bpv(tx_bpv), .loop_en(loop_en),
    .rx_power_down(pd), .equalizer_on(eq), .loss_threshold_db(thr),
    .peak_window_end(pwe), .los(los), .irq(irq));
  t1rx_line_model t1rx_line_model_i (.aclk(aclk), .run(aresetn),
    .marks(marks), .low_level(low), .line(line));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] g, input logic [33:0] x);
    comparisons++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch at %0t: got %h want %h", $time, g, x);
    end
  endtask : check
  task automatic wr(input logic [9:0] a, input logic [7:0] v);
    req.awaddr <= {a, 2'h0};
    req.wdata <= {24'h0, v};
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] x,
    input logic [1:0] r = RESP_OKAY);
    expq.push_back({r, x});
    req.araddr <= {a, 2'h0};
    req.arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
  endtask : rd
  task automatic txb;
    repeat (6) begin
      tx_in <= $random(seed);
      tvalid <= 1'b1;
      @(posedge aclk);
      tvalid <= 1'b0;
      @(posedge aclk);
    end
    @(posedge aclk);
  endtask : txb
  task automatic zeros(input int z);
    marks <= 1'b0;
    repeat (z * 16) @(posedge aclk);
    marks <= 1'b1;
    repeat (320) @(posedge aclk);
  endtask : zeros
  task automatic waitlos(input logic v);
    for (int i = 0; i < 8000 && los !== v; i++) @(posedge aclk);
    check(los, v);
  endtask : waitlos
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (rsp.rvalid && req.rready) begin
      e = expq.pop_front();
      check({rsp.rresp, rsp.rdata}, e);
    end
    if (ones_exp && rx_dv) check(rx_data, 1);
    if (ones_exp && tx_dv) check(tx_data, 1);
    if (tx_dv && tx_bpv) bpvn++;
  end
  // consecutive low-level bits seen before loss shows
  always @(posedge line.bit_clk) if (!los) nb = line.below ? nb + 1 : 0;
  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    stop_test;
  end
  initial begin
    req.bready <= 1'b1;
    req.rready <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(IDX_RX_CFG_A, 0);
    rd(IDX_RX_CFG_B, 8'h15);
    rd(IDX_RX_CFG_C, 8'h18);
    rd(10'h3ff, 0, RESP_SLVERR);
    repeat (4) begin
      d = $random(seed);
      wr(IDX_LOOP, d);
      rd(IDX_LOOP, d & MSK_LOOP);
      check(loop_en, {d[6:4], d[2:0]});
    end
    for (int i = 0; i < 4; i++) begin
      wr(IDX_RX_CFG_B, {3'h2, codes[i]});
      repeat (2) @(posedge aclk);
      check({eq, thr}, {1'b1, dbs[i]});
    end
    wr(IDX_RX_CFG_A, 8'h10);
    repeat (2) @(posedge aclk);
    check(pd, 1);
    wr(IDX_RX_CFG_A, 8'h00);
    // reset period code 2'b10: one window end every 128 bits
    while (!pwe) @(posedge aclk);
    do begin
      @(posedge aclk);
      if (rx_dv) pk++;
    end while (!pwe);
    check(pk, 128);
    $display("test registers done");
    wr(IDX_IRQ_ENABLE, 1);
    wr(IDX_LOS_RESP, 8'h03);
    low <= 1'b1;
    marks <= 1'b0;
    waitlos(1);
    check(nb, 175);
    check(irq, 1);
    ones_exp <= 1'b1;
    txb;
    repeat (200) @(posedge aclk);
    ones_exp <= 1'b0;
    rd(IDX_LINE_STATUS, 1);
    wr(IDX_IRQ_CLEAR, 1);
    repeat (2) @(posedge aclk);
    check(irq, 0);
    low <= 1'b0;
    marks <= 1'b1;
    waitlos(0);
    check(irq, 0); // clear event is masked
    $display("test loss done");
    wr(IDX_RX_CFG_A, 8'h01);
    wr(IDX_ERR_CTRL, 8'h04);
    zeros(40);
    wr(IDX_ERR_CTRL, 8'h05);
    rd(IDX_COUNT_LOW, 1);
    wr(IDX_ERR_CTRL, 8'h14);
    zeros(40);
    wr(IDX_ERR_CTRL, 8'h15);
    rd(IDX_COUNT_LOW, 1);
    wr(IDX_ERR_CTRL, 8'h54);
    txb;
    check(bpvn, 1);
    wr(IDX_ERR_CTRL, 8'h06);
    zeros(40);
    repeat (250) @(posedge aclk);
    rd(IDX_COUNT_LOW, 2);
    rd(IDX_COUNT_HIGH, 0);
    $display("test counting done");
    stop_test;
  end
endmodule : t1rx_decode_maint_tb
